// ---- design/ddo_params.svh ----
`ifndef DDO_PARAMS_SVH
`define DDO_PARAMS_SVH

// Register indices; the byte address on the bus is four times the index
`define DDO_IDX_DITHER_A 8'h4b
`define DDO_IDX_DITHER_B 8'h4c
`define DDO_IDX_LEFT_OFS 8'h4e
`define DDO_IDX_RIGHT_OFS 8'h4f
`define DDO_IDX_PIN_SEL 8'h55
`define DDO_IDX_STATUS 8'h60

// Reset value shared by every stored register
`define DDO_RST_REG 8'h00

// Address layout
`define DDO_ADDR_W 12
`define DDO_IDX_LSB 2
`define DDO_IDX_MSB 9

// Dither code layout: low byte from register a, top bits from register b
`define DDO_DITHER_W 11
`define DDO_DITHER_B_MSB 2

// Modulator sample width and dither weight: one code step is 2^-11 of 1/32 FS
`define DDO_SAMPLE_W 24
`define DDO_DITHER_SHIFT 7

// Pin select field
`define DDO_PIN_SEL_MSB 4
`define DDO_PIN_CODE_OFF 5'h00
`define DDO_PIN_CODE_PROC 5'h01
`define DDO_PIN_CODE_LAST 5'h1b
`define DDO_PIN_SRC_N 27

// Status register bits
`define DDO_STAT_PIN_BIT 0
`define DDO_STAT_SAT_BIT 1

`endif

// ---- design/ddo_pkg.sv ----
`include "ddo_params.svh"

package ddo_pkg;

  // APB request from the master, carried together
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [`DDO_ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
  } ddo_apb_req_t;

  // All state of the register bank
  typedef struct packed {
    logic [7:0] dither_a;
    logic [7:0] dither_b;
    logic [7:0] left_ofs;
    logic [7:0] right_ofs;
    logic [7:0] pin_sel;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic signed [`DDO_SAMPLE_W-1:0] mod_out;
    logic sat;
    logic pin;
    logic signed [8:0] left_shift;
    logic signed [8:0] right_shift;
  } ddo_state_t;

endpackage

// ---- design/ddo_pin_mux.sv ----
`timescale 1ns/1ns
`include "ddo_params.svh"

module ddo_pin_mux import ddo_pkg::*; (
  input wire logic [`DDO_PIN_SEL_MSB:0] sel_i,
  input wire logic [`DDO_PIN_SRC_N:1] src_i,
  output logic pin_o
);

  // Code zero holds the pin low; codes past the last listed source give zero
  always_comb begin
    pin_o = 1'b0;
    if (sel_i == `DDO_PIN_CODE_OFF) begin
      pin_o = 1'b0;
    end else if (sel_i <= `DDO_PIN_CODE_LAST) begin
      pin_o = src_i[sel_i];
    end
  end

endmodule

// ---- design/ddo_regs.sv ----
`timescale 1ns/1ns
`include "ddo_params.svh"

module ddo_regs import ddo_pkg::*; (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire ddo_apb_req_t apb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic signed [`DDO_SAMPLE_W-1:0] right_sec_mod_i,
  output logic signed [`DDO_SAMPLE_W-1:0] right_sec_mod_o,
  output logic signed [8:0] left_offset_o,
  output logic signed [8:0] right_offset_o,
  input wire logic [`DDO_PIN_SRC_N:1] pin_source_i,
  output logic serial_output_pin_o
);

  ddo_state_t st_reg;
  ddo_state_t st_next;
  logic [7:0] idx;
  logic addr_ok;
  logic setup;
  logic access;
  logic [`DDO_DITHER_W-1:0] dither_code;
  logic [`DDO_SAMPLE_W-1:0] dither_add;
  logic signed [`DDO_SAMPLE_W:0] mod_sum;
  logic pin_sel_out;

  // Offset adders take the negated code; nine bits so that code 80 becomes +128
  function automatic logic signed [8:0] offset_shift(input logic [7:0] code);
    logic signed [8:0] wide;
    wide = $signed({code[7], code});
    return 9'(-wide);
  endfunction

  // Index hits a register of this bank
  function automatic logic is_mapped(input logic [7:0] i);
    case (i)
      `DDO_IDX_DITHER_A, `DDO_IDX_DITHER_B, `DDO_IDX_LEFT_OFS,
      `DDO_IDX_RIGHT_OFS, `DDO_IDX_PIN_SEL, `DDO_IDX_STATUS: begin
        return 1'b1;
      end
      default: begin
        return 1'b0;
      end
    endcase
  endfunction

  // Address decode; high address bits and low byte bits must be zero
  assign idx = apb_i.paddr[`DDO_IDX_MSB:`DDO_IDX_LSB];
  assign addr_ok = (apb_i.paddr[`DDO_ADDR_W-1:`DDO_IDX_MSB+1] == '0) &&
                   (apb_i.paddr[`DDO_IDX_LSB-1:0] == '0) && is_mapped(idx);
  assign setup = apb_i.psel && !apb_i.penable;
  assign access = apb_i.psel && apb_i.penable && st_reg.pready;

  // Dither code spans both registers; scaled so code 2^11 would be 1/32 FS
  assign dither_code = {st_reg.dither_b[`DDO_DITHER_B_MSB:0], st_reg.dither_a};
  assign dither_add = `DDO_SAMPLE_W'(dither_code) << `DDO_DITHER_SHIFT;
  assign mod_sum = {right_sec_mod_i[`DDO_SAMPLE_W-1], right_sec_mod_i} +
                   $signed({1'b0, dither_add});

  ddo_pin_mux u_pin_mux (
    .sel_i(st_reg.pin_sel[`DDO_PIN_SEL_MSB:0]),
    .src_i(pin_source_i),
    .pin_o(pin_sel_out)
  );

  // Next state: bus slave with no wait state, then the datapaths
  always_comb begin
    st_next = st_reg;
    st_next.pready = 1'b0;
    // Setup phase prepares the answer so every bus output leaves a flop
    if (setup) begin
      st_next.pready = 1'b1;
      st_next.pslverr = !addr_ok;
      st_next.prdata = '0;
      case (idx)
        `DDO_IDX_DITHER_A: begin
          st_next.prdata[7:0] = st_reg.dither_a;
        end
        `DDO_IDX_DITHER_B: begin
          st_next.prdata[7:0] = st_reg.dither_b;
        end
        `DDO_IDX_LEFT_OFS: begin
          st_next.prdata[7:0] = st_reg.left_ofs;
        end
        `DDO_IDX_RIGHT_OFS: begin
          st_next.prdata[7:0] = st_reg.right_ofs;
        end
        `DDO_IDX_PIN_SEL: begin
          st_next.prdata[7:0] = st_reg.pin_sel;
        end
        `DDO_IDX_STATUS: begin
          st_next.prdata[`DDO_STAT_PIN_BIT] = st_reg.pin;
          st_next.prdata[`DDO_STAT_SAT_BIT] = st_reg.sat;
        end
        default: begin
          st_next.prdata = '0;
        end
      endcase
      if (!addr_ok) begin
        st_next.prdata = '0;
      end
    end
    // Write commits only on the access edge; lane 0 carries the byte
    if (access && apb_i.pwrite && !st_reg.pslverr && apb_i.pstrb[0]) begin
      case (idx)
        `DDO_IDX_DITHER_A: begin
          st_next.dither_a = apb_i.pwdata[7:0];
        end
        `DDO_IDX_DITHER_B: begin
          st_next.dither_b = apb_i.pwdata[7:0];
        end
        `DDO_IDX_LEFT_OFS: begin
          st_next.left_ofs = apb_i.pwdata[7:0];
        end
        `DDO_IDX_RIGHT_OFS: begin
          st_next.right_ofs = apb_i.pwdata[7:0];
        end
        `DDO_IDX_PIN_SEL: begin
          st_next.pin_sel = apb_i.pwdata[7:0];
        end
        default: begin
          st_next.pin_sel = st_reg.pin_sel;
        end
      endcase
    end
    // Offsets follow the new code in the same edge, no extra command needed
    st_next.left_shift = offset_shift(st_next.left_ofs);
    st_next.right_shift = offset_shift(st_next.right_ofs);
    // Clamp rather than wrap: a wrap would throw the modulator to the far rail
    st_next.sat = (mod_sum[`DDO_SAMPLE_W] != mod_sum[`DDO_SAMPLE_W-1]);
    if (st_next.sat) begin
      st_next.mod_out = mod_sum[`DDO_SAMPLE_W] ?
        {1'b1, {(`DDO_SAMPLE_W-1){1'b0}}} : {1'b0, {(`DDO_SAMPLE_W-1){1'b1}}};
    end else begin
      st_next.mod_out = mod_sum[`DDO_SAMPLE_W-1:0];
    end
    st_next.pin = pin_sel_out;
  end

  // All state in one register
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_reg <= '0;
      st_reg.dither_a <= `DDO_RST_REG;
      st_reg.dither_b <= `DDO_RST_REG;
      st_reg.left_ofs <= `DDO_RST_REG;
      st_reg.right_ofs <= `DDO_RST_REG;
      st_reg.pin_sel <= `DDO_RST_REG;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state flops
  assign prdata_o = st_reg.prdata;
  assign pready_o = st_reg.pready;
  assign pslverr_o = st_reg.pslverr;
  assign right_sec_mod_o = st_reg.mod_out;
  assign left_offset_o = st_reg.left_shift;
  assign right_offset_o = st_reg.right_shift;
  assign serial_output_pin_o = st_reg.pin;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);

  apb_ready_one_a: assert property (setup |=> pready_o)
    else $error("pready did not follow setup by one cycle");

  unmapped_err_a: assert property (setup && !addr_ok |=> pslverr_o && prdata_o == 32'h0)
    else $error("unmapped access not flagged");

  left_write_a: assert property (
      access && apb_i.pwrite && !pslverr_o && apb_i.pstrb[0] && idx == `DDO_IDX_LEFT_OFS
      |=> left_offset_o == -$signed({$past(apb_i.pwdata[7]), $past(apb_i.pwdata[7:0])}))
    else $error("left offset did not take the written code");

  right_write_a: assert property (
      access && apb_i.pwrite && !pslverr_o && apb_i.pstrb[0] && idx == `DDO_IDX_RIGHT_OFS
      |=> right_offset_o == -$signed({$past(apb_i.pwdata[7]), $past(apb_i.pwdata[7:0])}))
    else $error("right offset did not take the written code");

  left_top_code_a: assert property (
      st_reg.left_ofs == 8'h80 |-> left_offset_o == 9'sh080)
    else $error("left code 80 is not +128 quarter mV");

  right_small_code_a: assert property (
      st_reg.right_ofs == 8'h01 |-> right_offset_o == 9'sh1ff)
    else $error("right code 01 is not -1 quarter mV");

  dither_zero_a: assert property (
      dither_code == '0 |=> right_sec_mod_o == $past(right_sec_mod_i))
    else $error("zero dither changed the sample");

  dither_step_a: assert property (
      !st_next.sat |=> right_sec_mod_o ==
      $past(right_sec_mod_i) + $signed({1'b0, $past(dither_code), 7'h00}))
    else $error("dither amount wrong on secondary path");

  // A refused read answers zero, so only a clean read must show the stored byte
  read_back_a: assert property (
      access && !apb_i.pwrite && !pslverr_o && idx == `DDO_IDX_RIGHT_OFS
      |-> prdata_o == {24'h0, st_reg.right_ofs})
    else $error("right offset read back wrong");

  pin_off_a: assert property (
      st_reg.pin_sel[4:0] == 5'h00 ##1 st_reg.pin_sel[4:0] == 5'h00 |=> !serial_output_pin_o)
    else $error("pin not low with select off");

  pin_proc_a: assert property (
      st_reg.pin_sel[4:0] == 5'h01 |=> serial_output_pin_o == $past(pin_source_i[1]))
    else $error("pin does not follow processor output");

  // Out of reset every trim is zero, so no dither or offset leaks before software acts
  reset_zero_a: assert property (
      $rose(arst_n_i) |-> st_reg.dither_a == `DDO_RST_REG && st_reg.dither_b == `DDO_RST_REG
      && left_offset_o == 9'sh000 && right_offset_o == 9'sh000)
    else $error("trim registers not zero after reset");

endmodule

// ---- bench/testbench.sv ----
`timescale 1ns/1ns
`include "ddo_params.svh"

module testbench import ddo_pkg::*;;
  logic clk_i;
  logic arst_n_i;
  ddo_apb_req_t apb;
  logic [31:0] prdata, rd;
  logic pready, pslverr, pin, err;
  logic signed [`DDO_SAMPLE_W-1:0] mod_in, mod_out;
  logic signed [8:0] lofs, rofs;
  logic [`DDO_PIN_SRC_N:1] src;
  int bad_count, comparisons;

  ddo_regs dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .apb_i(apb), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .right_sec_mod_i(mod_in),
    .right_sec_mod_o(mod_out), .left_offset_o(lofs), .right_offset_o(rofs),
    .pin_source_i(src), .serial_output_pin_o(pin));

  // 125 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  // One comparison; unknowns never match
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // APB transfer; pready and data are read at the edge, before that edge's flop updates land
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk_i);
    apb <= '{1'b1, 1'b0, wr, {2'b00, idx, 2'b00}, wd, 4'hf};
    @(posedge clk_i);
    apb.penable <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    chk("pready", 32'h1, {31'h0, pready});
    apb <= '{1'b0, 1'b0, wr, {2'b00, idx, 2'b00}, wd, 4'hf};
  endtask

  // Let the datapath flops settle before looking
  task automatic settle();
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
  endtask

  task automatic regs_reset_and_rw();
    logic [7:0] idx [5] = '{8'h4b, 8'h4c, 8'h4e, 8'h4f, 8'h55};
    foreach (idx[i]) begin
      xfer(1'b0, idx[i], 32'h0);
      chk("reset value", 32'h0, rd);
      xfer(1'b1, idx[i], 32'hffff_ffa5);
      xfer(1'b0, idx[i], 32'h0);
      chk("read back", 32'ha5, rd);
      chk("no error", 32'h0, {31'h0, err});
      xfer(1'b1, idx[i], 32'h0);
    end
  endtask

  // Offset codes at both ends and around zero
  task automatic offsets();
    logic [7:0] code [5] = '{8'h7f, 8'h80, 8'h01, 8'hff, 8'h00};
    logic [8:0] shift [5] = '{9'h181, 9'h080, 9'h1ff, 9'h001, 9'h000};
    foreach (code[i]) begin
      xfer(1'b1, 8'h4e, {24'h0, code[i]});
      xfer(1'b1, 8'h4f, {24'h0, code[i]});
      @(negedge clk_i);
      chk("left shift", {23'h0, shift[i]}, {23'h0, lofs});
      chk("right shift", {23'h0, shift[i]}, {23'h0, rofs});
    end
  endtask

  // Smallest step, full code, then saturation at the top
  task automatic dither();
    @(posedge clk_i);
    mod_in <= 24'h001000;
    xfer(1'b1, 8'h4b, 32'h01);
    settle();
    chk("one step", 32'h1080, {8'h0, mod_out});
    xfer(1'b1, 8'h4b, 32'hff);
    xfer(1'b1, 8'h4c, 32'hff);
    settle();
    chk("full code", 32'h040f80, {8'h0, mod_out});
    chk("left untouched", 32'h0, {23'h0, lofs});
    @(posedge clk_i);
    mod_in <= 24'h7fffff;
    settle();
    chk("saturated", 32'h7fffff, {8'h0, mod_out});
    xfer(1'b0, 8'h60, 32'h0);
    chk("status sat", 32'h2, rd);
  endtask

  // Every select code with all sources high, then one source alone
  task automatic pin_select();
    @(posedge clk_i);
    src <= '1;
    for (int c = 0; c < 32; c++) begin
      xfer(1'b1, 8'h55, {24'h0, 3'b101, c[4:0]});
      settle();
      chk("pin level", {31'h0, c != 0 && c <= 27}, {31'h0, pin});
    end
    xfer(1'b0, 8'h55, 32'h0);
    chk("select read", 32'hbf, rd);
    src <= 27'h2;
    xfer(1'b1, 8'h55, 32'h02);
    settle();
    chk("source two", 32'h1, {31'h0, pin});
    xfer(1'b1, 8'h55, 32'h01);
    settle();
    chk("source one", 32'h0, {31'h0, pin});
  endtask

  // A hole in the map answers with an error and no data
  task automatic unmapped();
    xfer(1'b0, 8'h50, 32'h0);
    chk("hole error", 32'h1, {31'h0, err});
    chk("hole data", 32'h0, rd);
  endtask

  task automatic report_and_stop();
    if (bad_count == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Whole run is a few hundred cycles; this bound is generous
  initial begin
    #200000;
    bad_count++;
    report_and_stop();
  end

  initial begin
    apb = '0;
    mod_in = '0;
    src = '0;
    arst_n_i = 1'b0;
    repeat (20) @(posedge clk_i);
    arst_n_i <= 1'b1;
    regs_reset_and_rw();
    offsets();
    dither();
    pin_select();
    unmapped();
    report_and_stop();
  end
endmodule
